// ### sbfr_reader.sv
// Serial boot flash reader: memory-mapped read path onto serial flash with prefetch
//
// Notes on behaviour
// - Reset uses 24-bit addressing, four select lines
// - 24-bit mode: each select owns 16 MB
// - Wide mode maps whole region to select zero
// - Read in a window asserts that select
// - Byte, halfword, word reads; no write path
// - Override mode drives pins from override inputs
// - Data input level readable as status
// - Never more than one select low
// - Keep reading next word speculatively
// - Wide mode shifts 32 address bits
// - Serial clock divided from core clock
// - Quick read enable issues fast opcode
// - Select idle gap counted in serial periods
// - Config changes never corrupt a running read
// - Reset config: ~8.1 MHz, normal read, max gap
// - Sample data just before falling clock edge
`include "sbfr_regs.svh"

module sbfr_reader (
  input wire logic core_clk,
  input wire logic rst_b,
  // Bus read request, held until rd_ready
  input wire logic rd_req,
  input wire logic [27:0] rd_addr,
  input wire logic [1:0] rd_size,
  output logic rd_ready,
  output logic rd_valid,
  output logic [31:0] rd_data,
  // Boot serial timing configuration
  input wire logic [4:0] cfg_clk_div,
  input wire logic quick_read_enable,
  input wire logic wide_address_enable,
  input wire logic [3:0] chip_select_idle_gap,
  input wire logic serial_port_owned,
  // Pin override register fields
  input wire logic pin_override_enable,
  input wire logic po_sclk_oe,
  input wire logic po_sclk,
  input wire logic po_sdo_oe,
  input wire logic po_sdo,
  input wire logic [3:0] po_select_oe,
  input wire logic [3:0] po_select_n,
  output logic sampled_data_in_level,
  // Serial flash pins
  output logic sclk_o,
  output logic sclk_oe,
  output logic sdo_o,
  output logic sdo_oe,
  output logic [3:0] flash_select_n,
  output logic [3:0] flash_select_oe,
  input wire logic serial_data_in
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // First flash byte lands in the low lane of the word
  function automatic logic [31:0] sbfr_swap(input logic [31:0] w);
    sbfr_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // Keep only the lowest active-low select
  // Fixed priority: a bad override pattern can never enable two flashes
  function automatic logic [3:0] sbfr_one_low(input logic [3:0] n);
    logic [3:0] r;
    r = 4'hf;
    if (!n[0]) r = 4'he;
    else if (!n[1]) r = 4'hd;
    else if (!n[2]) r = 4'hb;
    else if (!n[3]) r = 4'h7;
    sbfr_one_low = r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sbfr_pkg::sbfr_state_s_t s_reg; // Registered state
  sbfr_pkg::sbfr_state_s_t s_next; // Next state
  logic [27:0] req_word; // Word address of the request
  logic [1:0] req_cs; // Select index from the address
  logic hit; // Request matches prefetched word
  logic last_ph; // Last core cycle of a serial period
  logic [4:0] half; // Cycle where serial clock rises
  logic [4:0] div_eff; // Clamped divider setting
  logic run; // Reader owns the pins

  // Whole words are fetched; byte lanes are the bus master's business
  assign req_word = {rd_addr[27:2], 2'b00};
  // Narrow mode ignores bits 27:26, so the four windows alias every 64 MB
  // Whole region on select zero in wide mode
  assign req_cs = wide_address_enable ? 2'b00 : rd_addr[25:24];
  // A prefetched word only counts for the select that fetched it
  assign hit = (req_word == s_reg.pf_addr) && (req_cs == s_reg.cs_idx);
  assign last_ph = (s_reg.ph == s_reg.div - 5'h01);
  assign half = s_reg.div >> 1;
  // Too small a divider cannot make a low and high phase
  assign div_eff = (cfg_clk_div < `SBFR_CLK_DIV_MIN) ? `SBFR_CLK_DIV_MIN : cfg_clk_div;
  assign run = serial_port_owned && !pin_override_enable;
  // Size only picks byte lanes; a whole word is always returned
  // Combinational, so a prefetch hit costs no extra cycle
  assign rd_ready = run && rd_req && (s_reg.st == sbfr_pkg::SBFR_HOLD) && hit;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // One serial period is div core cycles, counted by ph
  // Clock is low in the first half of a period and high in the second
  // Data out moves and data in is taken on the period's last cycle,
  // so the falling edge and the capture share one core edge
  // A frame: idle gap with selects high, opcode, address, optional
  // dummies, then 32 data bits; the select then stays low while the
  // next word is fetched ahead of the bus
  // Sequencer, serial clock generator and shifters
  always_comb begin
    s_next = s_reg;
    s_next.rd_valid = 1'b0;
    // Serial period phase counter and clock shape
    if (s_reg.st != sbfr_pkg::SBFR_IDLE && s_reg.st != sbfr_pkg::SBFR_HOLD) begin
      s_next.ph = last_ph ? 5'h00 : s_reg.ph + 5'h01;
    end else begin
      s_next.ph = 5'h00;
    end
    s_next.sclk = 1'b0;
    case (s_reg.st)
      sbfr_pkg::SBFR_IDLE: begin
        s_next.cs_act = 1'b0;
        // Nothing moves until a request arrives while the pins are ours
        if (run && rd_req) begin
          // Snapshot timing so later writes cannot disturb this access
          s_next.div = div_eff;
          s_next.fast = quick_read_enable;
          s_next.wide = wide_address_enable;
          s_next.cs_idx = req_cs;
          s_next.fetch_addr = req_word;
          s_next.gap_cnt = {1'b0, chip_select_idle_gap};
          s_next.st = sbfr_pkg::SBFR_GAP;
        end
      end
      sbfr_pkg::SBFR_GAP: begin
        // Selects stay high for gap plus one serial periods
        if (!run) begin
          // Pins lost before the command; nothing has been sent yet
          s_next.st = sbfr_pkg::SBFR_IDLE;
        end else if (last_ph) begin
          if (s_reg.gap_cnt == 5'h00) begin
            // Opcode then address, most significant bit first
            if (s_reg.wide) begin
              s_next.sh_out = {s_reg.fast ? `SBFR_OP_FAST_READ : `SBFR_OP_READ,
                               4'h0, s_reg.fetch_addr, 8'h00};
              s_next.bits = `SBFR_OPC_BITS + `SBFR_ADDR32_BITS;
            end else begin
              s_next.sh_out = {s_reg.fast ? `SBFR_OP_FAST_READ : `SBFR_OP_READ,
                               s_reg.fetch_addr[23:0], 16'h0000};
              s_next.bits = `SBFR_OPC_BITS + `SBFR_ADDR24_BITS;
            end
            // Fast read adds eight dummy clocks
            if (s_reg.fast) begin
              s_next.bits = s_next.bits + `SBFR_DUMMY_BITS;
            end
            s_next.cs_act = 1'b1;
            s_next.st = sbfr_pkg::SBFR_CMD;
          end else begin
            // One more idle serial period
            s_next.gap_cnt = s_reg.gap_cnt - 5'h01;
          end
        end
      end
      sbfr_pkg::SBFR_CMD, sbfr_pkg::SBFR_DATA: begin
        s_next.sclk = (s_next.ph >= half) && (s_next.ph != 5'h00);
        if (!run) begin
          // Override steals the pins; the access is dropped
          // Clock parked low too, so no edge shows with the selects released
          s_next.sclk = 1'b0;
          s_next.cs_act = 1'b0;
          s_next.st = sbfr_pkg::SBFR_IDLE;
        end else if (last_ph) begin
          // Sample just before the falling edge, shift after it
          s_next.sh_out = {s_reg.sh_out[46:0], 1'b0};
          s_next.bits = s_reg.bits - 6'h01;
          if (s_reg.st == sbfr_pkg::SBFR_DATA) begin
            s_next.sh_in = {s_reg.sh_in[30:0], serial_data_in};
          end
          if (s_reg.bits == 6'h01) begin
            if (s_reg.st == sbfr_pkg::SBFR_CMD) begin
              // Command and dummies out; data follows on the next period
              s_next.bits = `SBFR_WORD_BITS;
              s_next.st = sbfr_pkg::SBFR_DATA;
            end else begin
              // Word complete; select stays low for the next one
              s_next.pf_data = sbfr_swap({s_reg.sh_in[30:0], serial_data_in});
              s_next.pf_addr = s_reg.fetch_addr;
              s_next.st = sbfr_pkg::SBFR_HOLD;
            end
          end
        end
      end
      sbfr_pkg::SBFR_HOLD: begin
        // Clock parked, select held low until the bus asks
        if (!run) begin
          s_next.cs_act = 1'b0;
          s_next.st = sbfr_pkg::SBFR_IDLE;
        end else if (rd_req && hit) begin
          // Answer from the prefetched word, then fetch address n+1
          s_next.rd_valid = 1'b1;
          s_next.rd_data = s_reg.pf_data;
          s_next.fetch_addr = s_reg.pf_addr + 28'h0000004;
          s_next.bits = `SBFR_WORD_BITS;
          s_next.st = sbfr_pkg::SBFR_DATA;
        end else if (rd_req) begin
          // Miss: drop the prefetch, release select, restart
          s_next.cs_act = 1'b0;
          s_next.div = div_eff;
          s_next.fast = quick_read_enable;
          s_next.wide = wide_address_enable;
          s_next.cs_idx = req_cs;
          s_next.fetch_addr = req_word;
          s_next.pf_addr = 28'hfffffff;
          s_next.gap_cnt = {1'b0, chip_select_idle_gap};
          s_next.st = sbfr_pkg::SBFR_GAP;
        end
      end
      default: begin
        // Unused codes fall back to idle with the selects released
        s_next.cs_act = 1'b0;
        s_next.st = sbfr_pkg::SBFR_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // The whole state is one struct, so one register process covers it
  // Reset gives 24-bit mode, slow clock, normal read, largest gap
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg.st <= sbfr_pkg::SBFR_IDLE;
      s_reg.ph <= 5'h00;
      s_reg.bits <= 6'h00;
      s_reg.sh_out <= 48'h000000000000;
      s_reg.sh_in <= 32'h00000000;
      s_reg.cs_idx <= 2'h0;
      s_reg.cs_act <= 1'b0;
      s_reg.sclk <= 1'b0;
      s_reg.div <= `SBFR_CLK_DIV_RST;
      s_reg.fast <= `SBFR_FAST_RST;
      s_reg.wide <= `SBFR_WIDE_RST;
      s_reg.gap_cnt <= {1'b0, `SBFR_GAP_RST};
      s_reg.fetch_addr <= 28'h0000000;
      s_reg.pf_data <= 32'h00000000;
      s_reg.pf_addr <= 28'hfffffff;
      s_reg.rd_valid <= 1'b0;
      s_reg.rd_data <= 32'h00000000;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------
  logic [3:0] run_sel_n; // Select pattern from the sequencer

  // Only the addressed select can go low
  assign run_sel_n = s_reg.cs_act ? ~(4'h1 << s_reg.cs_idx) : 4'hf;

  assign rd_valid = s_reg.rd_valid;
  assign rd_data = s_reg.rd_data;
  assign sampled_data_in_level = serial_data_in;

  // Without ownership every enable drops and the pins float to the board
  // Override wins over ownership: it is how software reaches the flash alone
  // Override hands every pin to the override fields
  always_comb begin
    if (pin_override_enable) begin
      sclk_o = po_sclk;
      sclk_oe = po_sclk_oe;
      sdo_o = po_sdo;
      sdo_oe = po_sdo_oe;
      // Even in override only one select may go low
      flash_select_n = sbfr_one_low(po_select_n);
      flash_select_oe = po_select_oe;
    end else begin
      // Reader drives the pins only while it owns the port
      sclk_o = s_reg.sclk;
      sclk_oe = serial_port_owned;
      sdo_o = s_reg.sh_out[47];
      sdo_oe = serial_port_owned;
      flash_select_n = run_sel_n;
      flash_select_oe = {4{serial_port_owned}};
    end
  end

endmodule

// ### sbfr_regs.svh
// Constants for the serial boot flash reader: opcodes, reset values and field widths
`ifndef SBFR_REGS_SVH
`define SBFR_REGS_SVH

// ----------------------------------------------------------------
// Flash opcodes
// ----------------------------------------------------------------
`define SBFR_OP_READ 8'h03
`define SBFR_OP_FAST_READ 8'h0b
`define SBFR_DUMMY_BITS 6'h08

// ----------------------------------------------------------------
// Configuration reset values
// ----------------------------------------------------------------
// 250 MHz divided by 31 gives roughly 8.1 MHz
`define SBFR_CLK_DIV_RST 5'h1f
`define SBFR_CLK_DIV_MIN 5'h02
`define SBFR_GAP_RST 4'hf
`define SBFR_FAST_RST 1'b0
`define SBFR_WIDE_RST 1'b0

// ----------------------------------------------------------------
// Field widths and lengths
// ----------------------------------------------------------------
`define SBFR_ADDR_W 28
`define SBFR_NUM_CS 4
`define SBFR_WORD_BITS 6'h20
`define SBFR_ADDR24_BITS 6'h18
`define SBFR_ADDR32_BITS 6'h20
`define SBFR_OPC_BITS 6'h08

`endif

// ### sbfr_pkg.sv
// Types shared by the serial boot flash reader
package sbfr_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    SBFR_IDLE,
    SBFR_GAP,
    SBFR_CMD,
    SBFR_DATA,
    SBFR_HOLD
  } sbfr_state_t;

  // Whole state of the reader
  typedef struct packed {
    sbfr_state_t st;
    logic [4:0] ph;
    logic [5:0] bits;
    logic [47:0] sh_out;
    logic [31:0] sh_in;
    logic [1:0] cs_idx;
    logic cs_act;
    logic sclk;
    logic [4:0] div;
    logic fast;
    logic wide;
    logic [4:0] gap_cnt;
    logic [27:0] fetch_addr;
    logic [31:0] pf_data;
    logic [27:0] pf_addr;
    logic rd_valid;
    logic [31:0] rd_data;
  } sbfr_state_s_t;

endpackage

// ### sbfr_reader_chk.sv
// Port checker for the boot flash reader
module sbfr_reader_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic rd_req,
  input wire logic rd_ready,
  input wire logic rd_valid,
  input wire logic [4:0] cfg_clk_div,
  input wire logic [3:0] chip_select_idle_gap,
  input wire logic serial_port_owned,
  input wire logic pin_override_enable,
  input wire logic po_sclk_oe,
  input wire logic po_sclk,
  input wire logic po_sdo_oe,
  input wire logic po_sdo,
  input wire logic [3:0] po_select_oe,
  input wire logic sampled_data_in_level,
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic [3:0] flash_select_n,
  input wire logic [3:0] flash_select_oe,
  input wire logic serial_data_in
);
  logic [9:0] hi_cnt_reg; // Cycles with every select high, saturating
  logic [9:0] gap_need; // Shortest legal idle gap in core cycles
  logic ovr; // Pins under override control
  assign ovr = pin_override_enable;
  assign gap_need = 10'(chip_select_idle_gap + 5'h01) * 10'((cfg_clk_div < 5'h02) ? 5'h02 : cfg_clk_div);
  // Gap counter; starts saturated so the first frame is not judged on reset time
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) hi_cnt_reg <= 10'h3ff;
    else if (!(&flash_select_n)) hi_cnt_reg <= 10'h000;
    else if (hi_cnt_reg != 10'h3ff) hi_cnt_reg <= hi_cnt_reg + 10'h001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_ONE_SELECT:
    assert property ($countones(~flash_select_n) < 2) else $error("Two selects low");
  AST_VALID_FOLLOWS:
    assert property (rd_req && rd_ready |=> rd_valid) else $error("No answer after accept");
  AST_READY_SELECTED:
    assert property (rd_ready |-> flash_select_n != 4'hf) else $error("Ready without open frame");
  AST_REFUSE:
    assert property (ovr || !serial_port_owned |-> !rd_ready) else $error("Request taken in override");
  AST_OVR_PINS:
    assert property (ovr |-> {sclk_o, sclk_oe, sdo_o, sdo_oe, flash_select_oe} ==
      {po_sclk, po_sclk_oe, po_sdo, po_sdo_oe, po_select_oe}) else $error("Override pins differ");
  AST_SDI_LEVEL:
    assert property (sampled_data_in_level == serial_data_in) else $error("Data in level differs");
  AST_GAP:
    assert property ($fell(&flash_select_n) && !ovr && !$past(ovr) |-> hi_cnt_reg >= gap_need)
      else $error("Select idle gap too short");
  AST_SCLK_QUIET:
    assert property (!ovr && (&flash_select_n) |-> !sclk_o) else $error("Clock runs between frames");
  AST_RELEASED:
    assert property (!ovr && !serial_port_owned |-> !sclk_oe && !sdo_oe && flash_select_oe == 4'h0)
      else $error("Pins driven without ownership");
endmodule
bind sbfr_reader sbfr_reader_chk u_sbfr_reader_chk (.core_clk, .rst_b, .rd_req, .rd_ready,
  .rd_valid, .cfg_clk_div, .chip_select_idle_gap, .serial_port_owned, .pin_override_enable,
  .po_sclk_oe, .po_sclk, .po_sdo_oe, .po_sdo, .po_select_oe, .sampled_data_in_level, .sclk_o,
  .sclk_oe, .sdo_o, .sdo_oe, .flash_select_n, .flash_select_oe, .serial_data_in);

// ### sbfr_flash_model.sv
// Behavioural serial flash on the reader's select lines
module sbfr_flash_model (
  input wire logic sclk,
  input wire logic sdo,
  input wire logic [3:0] sel_n,
  input wire logic wide,
  output logic sdi,
  output logic [7:0] op,
  output logic [31:0] addr,
  output logic [1:0] cs,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt; // Rising edges in this frame
  int k; // Data bit index
  logic [7:0] b; // Byte being shifted out
  wire desel = &sel_n;
  initial begin
    sdi = 1'b0;
    frames = 0;
    cnt = 0;
  end
  // New frame: note the device, clear shifters
  always @(negedge desel) begin
    cnt = 0;
    op = 8'h00;
    addr = 32'h0;
    frames++;
    cs = sel_n[0] ? (sel_n[1] ? (sel_n[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
  end
  // Released line shows the inverse, never a stale level
  always @(posedge desel) sdi = ~sdi;
  // Opcode then address, MSB first, on rising clock
  always @(posedge sclk) begin
    if (!desel) begin
      if (cnt < 8) op = {op[6:0], sdo};
      else if (cnt < (wide ? 40 : 32)) addr = {addr[30:0], sdo};
      cnt++;
    end
  end
  // Data leaves on falling clock, quick read adds eight dummies
  always @(negedge sclk) begin
    k = cnt - (wide ? 40 : 32) - ((op == 8'h0b) ? 8 : 0);
    b = 8'(addr + 32'(k / 8)) ^ {cs, 6'h2d};
    if (!desel && k >= 0) sdi = b[3'(7 - k % 8)];
    else sdi = ~sdi;
  end
endmodule

// ### tb_top.sv
// Self-checking bench for the boot flash reader
`include "sbfr_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [27:0] a; logic w; logic f; logic [1:0] cs;} sbfr_row_t;
  logic core_clk = 1'b0, rst_b = 1'b0, rd_req = 1'b0, quick_read_enable = 1'b0;
  logic [27:0] rd_addr = 28'h0;
  logic [1:0] rd_size = 2'h2;
  logic [4:0] cfg_clk_div = 5'h04;
  logic wide_address_enable = 1'b0, serial_port_owned = 1'b1, pin_override_enable = 1'b0;
  logic [3:0] chip_select_idle_gap = 4'h1, po_select_oe = 4'h0, po_select_n = 4'hf;
  logic po_sclk_oe = 1'b0, po_sclk = 1'b0, po_sdo_oe = 1'b0, po_sdo = 1'b0;
  logic rd_ready, rd_valid, sampled_data_in_level, sclk_o, sclk_oe, sdo_o, sdo_oe;
  logic serial_data_in;
  logic [31:0] rd_data, m_addr, fa;
  logic [3:0] flash_select_n, flash_select_oe;
  logic [7:0] m_op;
  logic [1:0] m_cs;
  int m_frames, n, fr;
  int fail_count = 0;
  int checks_done = 0;
  // Windows of every select, both opcodes, narrow boot then wide
  sbfr_row_t rows [6] = '{'{28'h0000100, 0, 0, 0}, '{28'h1000200, 0, 1, 1},
    '{28'h2fffffc, 0, 0, 2}, '{28'h3000000, 0, 1, 3}, '{28'hfabc010, 1, 0, 0},
    '{28'h3000010, 1, 1, 0}};
  always #20 core_clk = ~core_clk;
  sbfr_reader u_sbfr_reader (.core_clk, .rst_b, .rd_req, .rd_addr, .rd_size, .rd_ready,
    .rd_valid, .rd_data, .cfg_clk_div, .quick_read_enable, .wide_address_enable,
    .chip_select_idle_gap, .serial_port_owned, .pin_override_enable, .po_sclk_oe, .po_sclk,
    .po_sdo_oe, .po_sdo, .po_select_oe, .po_select_n, .sampled_data_in_level, .sclk_o,
    .sclk_oe, .sdo_o, .sdo_oe, .flash_select_n, .flash_select_oe, .serial_data_in);
  sbfr_flash_model u_sbfr_flash_model (.sclk(sclk_o), .sdo(sdo_o), .sel_n(flash_select_n),
    .wide(wide_address_enable), .sdi(serial_data_in), .op(m_op), .addr(m_addr), .cs(m_cs),
    .frames(m_frames));
  // Flash content: low address byte mixed with the device number
  function automatic logic [31:0] word(input logic [1:0] c, input logic [31:0] a);
    for (int i = 0; i < 4; i++) word[8*i +: 8] = 8'(a + 32'(i)) ^ {c, 6'h2d};
  endfunction
  task automatic summarize();
    $display("Checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus read held until taken, answer looked at one cycle later
  task automatic rd(input logic [27:0] a, input logic [1:0] c, input logic [31:0] fl);
    @(negedge core_clk);
    rd_addr = a;
    rd_req = 1'b1;
    n = 0;
    #1;
    while (rd_ready !== 1'b1) begin
      n++;
      if (n > 4000) begin
        chk("rd_ready", 32'h1, 32'(rd_ready));
        summarize();
      end
      @(negedge core_clk);
      #1;
    end
    @(negedge core_clk);
    rd_req = 1'b0;
    chk("rd_valid", 32'h1, 32'(rd_valid));
    chk("rd_data", word(c, fl), rd_data);
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    foreach (rows[i]) begin
      wide_address_enable = rows[i].w;
      quick_read_enable = rows[i].f;
      rd_size = 2'(i % 3);
      fa = rows[i].w ? {4'h0, rows[i].a} : {8'h0, rows[i].a[23:0]};
      rd(rows[i].a, rows[i].cs, fa);
      chk("opcode", 32'(rows[i].f ? `SBFR_OP_FAST_READ : `SBFR_OP_READ), 32'(m_op));
      chk("flash_addr", fa, m_addr);
      chk("select", 32'(rows[i].cs), 32'(m_cs));
    end
    // Next word from prefetch, unharmed by a divider change meanwhile
    fr = m_frames;
    cfg_clk_div = 5'h06;
    rd(28'h3000014, 2'h0, 32'h3000014);
    chk("hit_wait", 32'h1, 32'(n < 140));
    chk("frames", 32'(fr), 32'(m_frames));
    rd(28'h3000100, 2'h0, 32'h3000100);
    chk("frames", 32'(fr + 1), 32'(m_frames));
    // Override owns pins; no fetch meanwhile, and the prefetch is dropped
    @(negedge core_clk);
    {pin_override_enable, po_sclk_oe, po_sdo_oe, po_sdo} = 4'hf;
    {po_select_oe, po_select_n} = 8'hf0;
    rd_req = 1'b0;
    repeat (20) @(negedge core_clk);
    #1;
    chk("flash_select_n", 32'he, 32'(flash_select_n));
    chk("sdi_level", 32'(serial_data_in), 32'(sampled_data_in_level));
    chk("rd_ready", 32'h0, 32'(rd_ready));
    chk("override_pins", 32'h7, 32'({sclk_o, sclk_oe, sdo_o, sdo_oe}));
    chk("flash_select_oe", 32'hf, 32'(flash_select_oe));
    @(negedge core_clk);
    pin_override_enable = 1'b0;
    po_select_n = 4'hf;
    fr = m_frames;
    rd(28'h3000104, 2'h0, 32'h3000104);
    chk("frames", 32'(fr + 1), 32'(m_frames));
    // Ownership lost mid-prefetch: pins released, clock and selects quiet
    repeat (40) @(negedge core_clk);
    serial_port_owned = 1'b0;
    repeat (3) @(negedge core_clk);
    #1;
    chk("released_pins", 32'h0, 32'({sclk_o, sclk_oe, sdo_oe, flash_select_oe}));
    chk("flash_select_n", 32'hf, 32'(flash_select_n));
    @(negedge core_clk);
    serial_port_owned = 1'b1;
    // Reset in mid-fetch, then narrow windows again
    @(negedge core_clk);
    wide_address_enable = 1'b0;
    rd_addr = 28'h1000040;
    rd_req = 1'b1;
    repeat (30) @(negedge core_clk);
    rst_b = 1'b0;
    #1;
    chk("rd_data", 32'h0, rd_data);
    chk("flash_select_n", 32'hf, 32'(flash_select_n));
    @(negedge core_clk);
    rst_b = 1'b1;
    rd(28'h1000040, 2'h1, 32'h40);
    summarize();
  end
endmodule
